// [hdl/rpf_regs.svh]
// Purpose: register indices, field positions, reset values and counts
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef RPF_REGS_SVH
`define RPF_REGS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define RPF_IDX_FMT 8'h33
`define RPF_IDX_PRE_LEN 8'h34
`define RPF_IDX_PRE_DET 8'h35
`define RPF_IDX_MARK3 8'h36
`define RPF_IDX_MARK2 8'h37
`define RPF_IDX_MARK1 8'h38
`define RPF_IDX_MARK0 8'h39
`define RPF_IDX_PKT_LEN 8'h3E
`define RPF_IDX_EXP_HDR3 8'h3F
`define RPF_IDX_MASK3 8'h43
`define RPF_IDX_RX_HDR3 8'h47
`define RPF_IDX_CTRL 8'h50
`define RPF_IDX_STATUS 8'h51

// ----------------------------------------
// fields
// ----------------------------------------
`define RPF_HDLEN_MSB 6
`define RPF_HDLEN_LSB 4
`define RPF_FIXLEN_BIT 3
`define RPF_MARKSEL_MSB 2
`define RPF_MARKSEL_LSB 1
`define RPF_PRE_MSB_BIT 0
`define RPF_FMT_MASK 8'h7F
`define RPF_THRESH_MSB 7
`define RPF_THRESH_LSB 3
`define RPF_RSSI_OFS_MSB 2
`define RPF_RSSI_OFS_LSB 0

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define RPF_RST_PRE_LEN 8'h08
`define RPF_RST_MARK3 8'h2D
`define RPF_RST_MARK2 8'hD4
`define RPF_MIN_PRE_NIB 9'h001
`define RPF_MAX_HDR_BYTES 3'h4
`define RPF_MARKER_SLACK_BITS 12'h020
// raw level is in 1 dB steps; one offset unit adds 4 dB
`define RPF_RSSI_STEP_SHIFT 2

`endif

// [hdl/rpf_pkg.sv]
// Purpose: types shared by the receive packet format block
// Assumes: nothing
// Notes:   state codes are one-hot
package rpf_pkg;
   typedef enum logic [5:0] {
      RPF_IDLE     = 6'h01,
      RPF_PREAMBLE = 6'h02,
      RPF_MARKER   = 6'h04,
      RPF_HEADER   = 6'h08,
      RPF_LENGTH   = 6'h10,
      RPF_PAYLOAD  = 6'h20
   } rpf_state_type;
endpackage

// [hdl/rpf_top.sv]
// Purpose: receive packet format configuration and packet parser, APB slave
// Assumes: demodulated bits arrive on pclk with a one-cycle valid strobe
// Notes:   bits arrive most significant bit first within each byte
//
// Function
// - header byte count from field, byte 3 first
// - fixed length: no length byte in header
// - marker byte count selects bytes 3 downward
// - preamble length counted in nibbles
// - preamble MSB in format register bit 0
// - preamble length zero acts as one
// - preamble length low byte resets to 8
// - detector threshold counts nibbles of consecutive alternating bits
// - level offset adds 4 dB per unit
// - marker byte 3 resets to 2D
// - marker byte 2 resets to D4
// - fixed length takes programmed packet length
// - header compare only on mask bits set
`timescale 1ns/1ps
`default_nettype none
`include "rpf_regs.svh"
module rpf_top
   import rpf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   input wire logic [7:0] rssi_raw,
   output logic [7:0] rssi_level,
   output logic [8:0] preamble_nibbles,
   output logic marker_found,
   output logic [7:0] rx_byte,
   output logic rx_byte_valid,
   output logic packet_done,
   output logic header_match
);

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic [6:0] fmt_ctrl;
   logic [7:0] pre_len_low, pre_det, pkt_len;
   logic [7:0] marker_byte [0:3];
   logic [7:0] exp_hdr [0:3];
   logic [7:0] hdr_mask [0:3];
   logic [7:0] rx_hdr [0:3];
   logic rx_enable, hdr_ok;
   rpf_state_type state;

   logic [7:0] idx, rd_value;
   logic addr_ok, setup, wr_go;

   assign idx = paddr[9:2];
   assign setup = psel && !penable;
   assign wr_go = psel && penable && pready && pwrite && !pslverr;

   // read decode; unmapped or misaligned answers with an error
   always_comb begin
      rd_value = 8'h00;
      addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
      if (idx == `RPF_IDX_FMT) begin
         rd_value = {1'b0, fmt_ctrl};
      end else if (idx == `RPF_IDX_PRE_LEN) begin
         rd_value = pre_len_low;
      end else if (idx == `RPF_IDX_PRE_DET) begin
         rd_value = pre_det;
      end else if (idx >= `RPF_IDX_MARK3 && idx <= `RPF_IDX_MARK0) begin
         rd_value = marker_byte[2'(`RPF_IDX_MARK0 - idx)];
      end else if (idx == `RPF_IDX_PKT_LEN) begin
         rd_value = pkt_len;
      end else if (idx >= `RPF_IDX_EXP_HDR3 && idx < `RPF_IDX_MASK3) begin
         rd_value = exp_hdr[2'(3'h3 - 3'(idx - `RPF_IDX_EXP_HDR3))];
      end else if (idx >= `RPF_IDX_MASK3 && idx < `RPF_IDX_RX_HDR3) begin
         rd_value = hdr_mask[2'(3'h3 - 3'(idx - `RPF_IDX_MASK3))];
      end else if (idx >= `RPF_IDX_RX_HDR3 && idx < 8'(`RPF_IDX_RX_HDR3 + 8'h04)) begin
         rd_value = rx_hdr[2'(3'h3 - 3'(idx - `RPF_IDX_RX_HDR3))];
      end else if (idx == `RPF_IDX_CTRL) begin
         rd_value = {7'h00, rx_enable};
      end else if (idx == `RPF_IDX_STATUS) begin
         rd_value = {1'b0, hdr_ok, state};
      end else begin
         addr_ok = 1'b0;
      end
   end

   // ----------------------------------------
   // apb answer: one access cycle, no waits
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= !addr_ok || (pwrite && idx >= `RPF_IDX_RX_HDR3
                                    && idx < 8'(`RPF_IDX_RX_HDR3 + 8'h04))
                       || (pwrite && idx == `RPF_IDX_STATUS);
            // a refused read must not leak the word behind a misaligned address
            prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : {24'h00_0000, rd_value};
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // software writes, on the access edge only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmt_ctrl <= 7'h00;
         pre_len_low <= `RPF_RST_PRE_LEN;
         pre_det <= 8'h00;
         marker_byte[3] <= `RPF_RST_MARK3;
         marker_byte[2] <= `RPF_RST_MARK2;
         marker_byte[1] <= 8'h00;
         marker_byte[0] <= 8'h00;
         pkt_len <= 8'h00;
         rx_enable <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            exp_hdr[i] <= 8'h00;
            hdr_mask[i] <= 8'h00;
         end
      end else if (wr_go) begin
         if (idx == `RPF_IDX_FMT) begin
            fmt_ctrl <= 7'(pwdata[7:0] & `RPF_FMT_MASK);
         end else if (idx == `RPF_IDX_PRE_LEN) begin
            pre_len_low <= pwdata[7:0];
         end else if (idx == `RPF_IDX_PRE_DET) begin
            pre_det <= pwdata[7:0];
         end else if (idx >= `RPF_IDX_MARK3 && idx <= `RPF_IDX_MARK0) begin
            marker_byte[2'(`RPF_IDX_MARK0 - idx)] <= pwdata[7:0];
         end else if (idx == `RPF_IDX_PKT_LEN) begin
            pkt_len <= pwdata[7:0];
         end else if (idx >= `RPF_IDX_EXP_HDR3 && idx < `RPF_IDX_MASK3) begin
            exp_hdr[2'(3'h3 - 3'(idx - `RPF_IDX_EXP_HDR3))] <= pwdata[7:0];
         end else if (idx >= `RPF_IDX_MASK3 && idx < `RPF_IDX_RX_HDR3) begin
            hdr_mask[2'(3'h3 - 3'(idx - `RPF_IDX_MASK3))] <= pwdata[7:0];
         end else if (idx == `RPF_IDX_CTRL) begin
            rx_enable <= pwdata[0];
         end
      end
   end

   // ----------------------------------------
   // derived settings
   // ----------------------------------------
   logic [8:0] pre_nib;
   logic [2:0] hdr_count;
   logic fixed_len;
   logic [1:0] mark_sel;
   logic [4:0] thresh;
   logic [6:0] thresh_bits;
   logic [11:0] search_limit;
   logic [2:0] ofs;

   assign pre_nib = ({fmt_ctrl[`RPF_PRE_MSB_BIT], pre_len_low} == 9'h000) ? `RPF_MIN_PRE_NIB
                    : {fmt_ctrl[`RPF_PRE_MSB_BIT], pre_len_low};
   // codes above four still mean all four bytes
   assign hdr_count = (fmt_ctrl[`RPF_HDLEN_MSB:`RPF_HDLEN_LSB] > `RPF_MAX_HDR_BYTES)
                      ? `RPF_MAX_HDR_BYTES : fmt_ctrl[`RPF_HDLEN_MSB:`RPF_HDLEN_LSB];
   assign fixed_len = fmt_ctrl[`RPF_FIXLEN_BIT];
   assign mark_sel = fmt_ctrl[`RPF_MARKSEL_MSB:`RPF_MARKSEL_LSB];
   assign thresh = pre_det[`RPF_THRESH_MSB:`RPF_THRESH_LSB];
   assign ofs = pre_det[`RPF_RSSI_OFS_MSB:`RPF_RSSI_OFS_LSB];
   // a zero threshold still needs one nibble
   assign thresh_bits = (thresh == 5'h00) ? 7'h04 : {thresh, 2'h0};
   assign search_limit = {1'b0, pre_nib, 2'h0} + `RPF_MARKER_SLACK_BITS;

   // compares the newest bits against bytes 3 downward
   function automatic logic marker_match(input logic [31:0] win, input logic [1:0] sel,
                                         input logic [31:0] word);
      logic r;
      r = 1'b0;
      unique case (sel)
         2'h0: r = (win[7:0] == word[31:24]);
         2'h1: r = (win[15:0] == word[31:16]);
         2'h2: r = (win[23:0] == word[31:8]);
         2'h3: r = (win == word);
      endcase
      return r;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preamble_nibbles <= `RPF_MIN_PRE_NIB;
         rssi_level <= 8'h00;
      end else begin
         preamble_nibbles <= pre_nib;
         // saturates rather than wraps so a strong signal never reads weak
         if ({1'b0, rssi_raw} + {4'h0, ofs, 2'h0} > 9'h0FF) begin
            rssi_level <= 8'hFF;
         end else begin
            rssi_level <= rssi_raw + {3'h0, ofs, 2'h0};
         end
      end
   end

   // ----------------------------------------
   // packet parser
   // ----------------------------------------
   logic last_bit;
   logic [6:0] alt_bits;
   logic [31:0] window, next_window;
   logic [11:0] search_bits;
   logic [2:0] bit_cnt;
   logic [7:0] byte_sr, next_byte;
   logic byte_done;
   logic [2:0] hdr_left;
   logic [1:0] hdr_idx;
   logic [7:0] pay_left;

   assign next_window = {window[30:0], rx_bit};
   assign next_byte = {byte_sr[6:0], rx_bit};
   assign byte_done = rx_bit_valid && (bit_cnt == 3'h7);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= RPF_IDLE;
         last_bit <= 1'b0;
         alt_bits <= 7'h00;
         window <= 32'h0000_0000;
         search_bits <= 12'h000;
         bit_cnt <= 3'h0;
         byte_sr <= 8'h00;
         hdr_left <= 3'h0;
         hdr_idx <= 2'h3;
         pay_left <= 8'h00;
         hdr_ok <= 1'b1;
         marker_found <= 1'b0;
         rx_byte <= 8'h00;
         rx_byte_valid <= 1'b0;
         packet_done <= 1'b0;
         header_match <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            rx_hdr[i] <= 8'h00;
         end
      end else begin
         marker_found <= 1'b0;
         rx_byte_valid <= 1'b0;
         packet_done <= 1'b0;
         if (rx_bit_valid) begin
            last_bit <= rx_bit;
            byte_sr <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (!rx_enable) begin
            state <= RPF_IDLE;
         end else begin
            unique case (state)
               RPF_IDLE: begin
                  alt_bits <= 7'h00;
                  state <= RPF_PREAMBLE;
               end
               RPF_PREAMBLE: if (rx_bit_valid) begin
                  if (rx_bit != last_bit && alt_bits != 7'h7F) begin
                     alt_bits <= alt_bits + 7'h01;
                  end else if (rx_bit == last_bit) begin
                     alt_bits <= 7'h01;
                  end
                  if (rx_bit != last_bit && alt_bits + 7'h01 >= thresh_bits) begin
                     state <= RPF_MARKER;
                     window <= 32'h0000_0000;
                     search_bits <= 12'h000;
                  end
               end
               RPF_MARKER: if (rx_bit_valid) begin
                  window <= next_window;
                  search_bits <= search_bits + 12'h001;
                  if (marker_match(next_window, mark_sel, {marker_byte[3], marker_byte[2],
                                                           marker_byte[1], marker_byte[0]})) begin
                     marker_found <= 1'b1;
                     bit_cnt <= 3'h0;
                     hdr_ok <= 1'b1;
                     hdr_idx <= 2'h3;
                     hdr_left <= hdr_count;
                     pay_left <= pkt_len;
                     if (hdr_count != 3'h0) begin
                        state <= RPF_HEADER;
                     end else if (!fixed_len) begin
                        state <= RPF_LENGTH;
                     end else begin
                        state <= RPF_PAYLOAD;
                     end
                  end else if (search_bits >= search_limit) begin
                     state <= RPF_PREAMBLE;
                     alt_bits <= 7'h00;
                  end
               end
               RPF_HEADER: if (byte_done) begin
                  rx_hdr[hdr_idx] <= next_byte;
                  if (((next_byte ^ exp_hdr[hdr_idx]) & hdr_mask[hdr_idx]) != 8'h00) begin
                     hdr_ok <= 1'b0;
                  end
                  hdr_idx <= hdr_idx - 2'h1;
                  hdr_left <= hdr_left - 3'h1;
                  if (hdr_left == 3'h1) begin
                     state <= fixed_len ? RPF_PAYLOAD : RPF_LENGTH;
                  end
               end
               RPF_LENGTH: if (byte_done) begin
                  pay_left <= next_byte;
                  state <= RPF_PAYLOAD;
               end
               RPF_PAYLOAD: begin
                  // an empty packet ends at once
                  if (pay_left == 8'h00) begin
                     packet_done <= 1'b1;
                     header_match <= hdr_ok;
                     state <= RPF_PREAMBLE;
                     alt_bits <= 7'h00;
                  end else if (byte_done) begin
                     rx_byte <= next_byte;
                     rx_byte_valid <= 1'b1;
                     pay_left <= pay_left - 8'h01;
                  end
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// [test/rpf_top_asserts.sv]
// Purpose: port checks for rpf_top
// Assumes: register byte address is four times its index
// Notes:   mirrors only the registers that the checks need
`timescale 1ns/1ps
`default_nettype none
module rpf_top_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_bit_valid,
   input wire logic [7:0] rssi_raw,
   input wire logic [7:0] rssi_level,
   input wire logic [8:0] preamble_nibbles,
   input wire logic marker_found,
   input wire logic rx_byte_valid
);
   // ----------------------------------------
   // register mirror
   // ----------------------------------------
   logic pre_msb;
   logic [7:0] pre_low;
   logic [2:0] ofs;
   logic [8:0] eff_pre;
   logic [9:0] sum;
   logic [7:0] lvl_exp;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_msb <= 1'b0;
         pre_low <= 8'h08;
         ofs <= 3'h0;
      end else if (psel && penable && pwrite && pready && !pslverr) begin
         if (paddr == 12'h0CC) pre_msb <= pwdata[0];
         if (paddr == 12'h0D0) pre_low <= pwdata[7:0];
         if (paddr == 12'h0D4) ofs <= pwdata[2:0];
      end
   end
   // zero length acts as one nibble
   assign eff_pre = ({pre_msb, pre_low} == 9'h000) ? 9'h001 : {pre_msb, pre_low};
   assign sum = {2'b00, rssi_raw} + {5'h00, ofs, 2'b00};
   assign lvl_exp = (sum[9:8] != 2'b00) ? 8'hFF : sum[7:0];
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused access returned data");
   chk_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("misaligned access not refused");
   chk_rssi_sum: assert property ($past(presetn) |-> rssi_level == $past(lvl_exp))
      else $error("signal level offset wrong");
   chk_pre_len: assert property ($past(presetn) |-> preamble_nibbles == $past(eff_pre))
      else $error("effective preamble length wrong");
   chk_marker_cause: assert property (marker_found |-> $past(rx_bit_valid) && !$past(marker_found))
      else $error("marker pulse without bit");
   chk_byte_cause: assert property (rx_byte_valid |-> $past(rx_bit_valid))
      else $error("byte pulse without bit");
endmodule
bind rpf_top rpf_top_asserts u_rpf_top_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_bit_valid, .rssi_raw, .rssi_level,
   .preamble_nibbles, .marker_found, .rx_byte_valid);
`default_nettype wire

// [test/rpf_tx_model.sv]
// Purpose: remote transmitter feeding demodulated bits
// Assumes: one valid pulse per bit, msb first
// Notes:   gap sets prompt or slow pacing
`timescale 1ns/1ps
`default_nettype none
module rpf_tx_model (
   input wire logic pclk,
   output logic rx_bit,
   output logic rx_bit_valid
);
   initial begin
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
   end
   // idle line shows the inverse so a stale bit is never mistaken
   task automatic send(input logic [31:0] v, input int n, input int gap);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge pclk);
         rx_bit <= v[i];
         rx_bit_valid <= 1'b1;
         @(posedge pclk);
         rx_bit_valid <= 1'b0;
         rx_bit <= ~v[i];
         repeat (gap) @(posedge pclk);
      end
   endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench for rpf_top
// Assumes: apb answers when pready is sampled high
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic rx_bit, rx_bit_valid, marker_found, rx_byte_valid, packet_done, header_match;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [7:0] rssi_raw, rssi_level, rx_byte;
   logic [8:0] preamble_nibbles;
   logic [7:0] got[$];
   int n_mismatch, total_checks, n_mark, n_done;
   rpf_top u_rpf_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rx_bit, .rx_bit_valid, .rssi_raw, .rssi_level, .preamble_nibbles,
      .marker_found, .rx_byte, .rx_byte_valid, .packet_done, .header_match);
   rpf_tx_model u_rpf_tx_model (.pclk, .rx_bit, .rx_bit_valid);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (rx_byte_valid === 1'b1) got.push_back(rx_byte);
      if (marker_found === 1'b1) n_mark++;
      if (packet_done === 1'b1) n_done++;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         n_mismatch++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      err = pslverr;
      chk("pready", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, ad(i), d);
      chk("pslverr", 32'h0, {31'h0, err});
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      apb(1'b0, ad(i), 8'h00);
      chk($sformatf("reg %h", i), {24'h0, e}, rdat);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_vals;
      rd(8'h34, 8'h08);
      rd(8'h36, 8'h2D);
      rd(8'h37, 8'hD4);
      chk("preamble_nibbles", 32'h8, {23'h0, preamble_nibbles});
   endtask
   task automatic t_fields;
      wr(8'h33, 8'hFF);
      rd(8'h33, 8'h7F);
      repeat (2) @(posedge pclk);
      chk("preamble_nibbles", 32'h108, {23'h0, preamble_nibbles});
      wr(8'h33, 8'h00);
      wr(8'h34, 8'h00);
      repeat (2) @(posedge pclk);
      chk("preamble_nibbles", 32'h1, {23'h0, preamble_nibbles});
      wr(8'h34, 8'h08);
      apb(1'b0, ad(8'h3A), 8'h00);
      chk("pslverr", 32'h1, {31'h0, err});
      apb(1'b1, 12'h0D1, 8'hFF);
      chk("pslverr", 32'h1, {31'h0, err});
      apb(1'b0, 12'h0D1, 8'h00);
      chk("pslverr", 32'h1, {31'h0, err});
      chk("refused rdata", 32'h0, rdat);
      apb(1'b1, ad(8'h51), 8'hFF);
      chk("pslverr", 32'h1, {31'h0, err});
      rd(8'h34, 8'h08);
   endtask
   task automatic t_rssi;
      wr(8'h35, 8'h2B);
      rd(8'h35, 8'h2B);
      rssi_raw <= 8'h10;
      repeat (3) @(posedge pclk);
      chk("rssi_level", 32'h1C, {24'h0, rssi_level});
      rssi_raw <= 8'hF8;
      repeat (3) @(posedge pclk);
      chk("rssi_level", 32'hFF, {24'h0, rssi_level});
   endtask
   task automatic t_pkt(input logic [7:0] fmt, input logic [31:0] mk, input int mbits,
      input logic [31:0] hd, input int hbits, input logic [15:0] pay, input int pbits);
      wr(8'h33, fmt);
      got.delete();
      n_mark = 0;
      n_done = 0;
      u_rpf_tx_model.send(32'hAAAAAAAA, 32, 0);
      u_rpf_tx_model.send(mk, mbits, 2);
      u_rpf_tx_model.send(hd, hbits, 1);
      u_rpf_tx_model.send({16'h0, pay}, pbits, 3);
      repeat (8) @(posedge pclk);
      chk("marker count", 32'h1, n_mark);
      chk("packet_done count", 32'h1, n_done);
      chk("payload bytes", pbits / 8, got.size());
   endtask
   task automatic t_pkt1;
      wr(8'h3E, 8'h02);
      wr(8'h3F, 8'hA5);
      wr(8'h40, 8'h3C);
      wr(8'h43, 8'hFF);
      wr(8'h44, 8'hF0);
      wr(8'h50, 8'h01);
      t_pkt(8'h2E, 32'h2DD40000, 32, 32'hA53F, 16, 16'h1122, 16);
      chk("payload 0", 32'h11, {24'h0, got[0]});
      chk("payload 1", 32'h22, {24'h0, got[1]});
      chk("header_match", 32'h1, {31'h0, header_match});
      rd(8'h47, 8'hA5);
      rd(8'h48, 8'h3F);
   endtask
   task automatic t_pkt2;
      t_pkt(8'h10, 32'h2D, 8, 32'h5A01, 16, 16'h0077, 8);
      chk("payload 0", 32'h77, {24'h0, got[0]});
      chk("header_match", 32'h0, {31'h0, header_match});
      rd(8'h47, 8'h5A);
   endtask
   task automatic t_pkt3;
      wr(8'h3E, 8'h00);
      t_pkt(8'h0A, 32'h2DD4, 16, 32'h0, 0, 16'h0, 0);
      chk("header_match", 32'h1, {31'h0, header_match});
   endtask
   task automatic t_off;
      wr(8'h50, 8'h00);
      n_mark = 0;
      u_rpf_tx_model.send(32'hAAAAAAAA, 32, 0);
      u_rpf_tx_model.send(32'h2DD4, 16, 0);
      repeat (4) @(posedge pclk);
      chk("marker while off", 32'h0, n_mark);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rssi_raw = 8'h00;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_vals();
      t_fields();
      t_rssi();
      t_pkt1();
      t_pkt2();
      t_pkt3();
      t_off();
      summarize();
   end
   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
